// ==== include/ssp_params.svh ====
// Constants of the serial byte port and its partner
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
`define SSP_CTRL_RESET 4'h0
`define SSP_CLKSEL_POS 2
`define SSP_PINFN_POS 0
`define SSP_HALF_DIV8 3'h4
`define SSP_HALF_DIV4 3'h2
`define SSP_HALF_DIV2 3'h1
`define SSP_LAST_BIT 3'h7
`define SSP_HOST_HALF 4
`define SSP_H_CTRL 5'h00
`define SSP_H_TXDATA 5'h04
`define SSP_H_RXDATA 5'h08
`define SSP_H_STATUS 5'h0C
`define SSP_H_CMD 5'h10
`define SSP_HC_MASTER 0
`define SSP_HC_ISTX 1
`define SSP_HC_USERDY 2
`define SSP_HS_DONE 0
`define SSP_HS_BUSY 1
`define SSP_HS_RDY 2
`define SSP_HCMD_GO 0
`define SSP_RESP_OKAY 2'h0
`define SSP_RESP_SLVERR 2'h2
`endif

// ==== include/ssp_pkg.sv ====
// Types for the two ends of the serial byte port: clock select for the device, states for the partner
package ssp_pkg;
  typedef enum logic [1:0] {
    SSP_DIV8,
    SSP_DIV4,
    SSP_DIV2,
    SSP_EXT
  } ssp_clksel_t;
  typedef enum logic [2:0] {
    HS_IDLE,
    HS_SETUP,
    HS_WAITRDY,
    HS_SHIFT,
    HS_CLOSE
  } ssp_host_state_t;
endpackage

// ==== include/ssp_link_if.sv ====
// Serial link between the port and its partner, with pull-up wire resolution
`timescale 1ns/1ps
interface ssp_link_if;
  logic devSckO;
  logic devSckOe;
  logic hostSckO;
  logic hostSckOe;
  logic devDaO;
  logic devDaOe;
  logic devDbO;
  logic devDbOe;
  logic hostDbO;
  logic hostDbOe;
  logic devRdyO;
  logic devRdyOe;
  logic hostRdyO;
  logic hostRdyOe;
  logic lineSck;
  logic lineDa;
  logic lineDb;
  logic lineRdy;
  // Pulled-up lines; any driver pulling low wins
  assign lineSck = (devSckOe ? devSckO : 1'b1) & (hostSckOe ? hostSckO : 1'b1);
  assign lineDa = devDaOe ? devDaO : 1'b1;
  assign lineDb = (devDbOe ? devDbO : 1'b1) & (hostDbOe ? hostDbO : 1'b1);
  assign lineRdy = (devRdyOe ? devRdyO : 1'b1) & (hostRdyOe ? hostRdyO : 1'b1);
  modport dev (
    output devSckO, devSckOe, devDaO, devDaOe, devDbO, devDbOe, devRdyO, devRdyOe,
    input lineSck, lineDa, lineDb, lineRdy
  );
  modport host (
    output hostSckO, hostSckOe, hostDbO, hostDbOe, hostRdyO, hostRdyOe,
    input lineSck, lineDa, lineDb, lineRdy
  );
endinterface

// ==== verilog/ssp_dev.sv ====
// Serial byte port, device end: control register, shift register, clock, done flag
`timescale 1ns/1ps
`include "ssp_params.svh"
module ssp_dev (
  input wire logic clk_sys, // Instruction clock
  input wire logic nrst, // Core reset, active low
  ssp_link_if.dev link, // Serial pins
  input wire logic wrCtrl, // Write control register from accumulator
  input wire logic [3:0] accIn, // Accumulator nibble
  input wire logic [3:0] bIn, // Second register nibble
  output logic [3:0] ctrlOut, // Control register copy for the accumulator
  input wire logic loadSr, // Load shift register from accumulator pair
  output logic [7:0] srOut, // Shift register contents
  input wire logic start, // Serial start instruction
  input wire logic skipTest, // Skip-if-done instruction
  output logic skipTaken, // Pulse: next instruction is skipped
  input wire logic intSel, // Interrupt control bit: 1 interrupt, 0 skip
  output logic intReq, // Pulse: serial interrupt taken
  output logic doneFlag, // Transfer-done flag
  input wire logic [2:0] portOut, // Plain port levels for clock, out, in pins
  input wire logic [2:0] portOe, // Plain port output enables
  output logic [2:0] portIn, // Sampled levels of the three pins
  input wire logic hsSetHigh, // Set handshake bit high
  input wire logic hsSetLow, // Clear handshake bit low
  input wire logic hsDirOut, // Handshake bit drives the ready line
  input wire logic hsTestLow, // Skip-if-port-bit-low instruction
  output logic hsSkip // Pulse: ready line was low
);
  logic [3:0] ctrl_q;
  logic [7:0] sr_q;
  logic [2:0] bitCnt_q;
  logic [2:0] halfCnt_q;
  logic [2:0] portIn_q;
  logic soutBit_q;
  logic intSck_q;
  logic sckPrev_q;
  logic active_q;
  logic done_q;
  logic intReq_q;
  logic skipTaken_q;
  logic hsLevel_q;
  logic hsSkip_q;
  ssp_pkg::ssp_clksel_t clkSel;
  logic [1:0] pinFn;
  logic [2:0] halfLen;
  logic extClk;
  logic sckSel;
  logic soutSel;
  logic sinSel;
  logic sinBit;
  logic halfEnd;
  logic intRise;
  logic intFall;
  logic extRise;
  logic extFall;
  logic rise;
  logic fall;
  logic shiftEn;
  logic doneSet;
  logic intTake;
  logic skipHit;

  function automatic logic ssp_uses_sck(input logic [1:0] fn);
    return fn != 2'h0;
  endfunction

  assign clkSel = ssp_pkg::ssp_clksel_t'(ctrl_q[`SSP_CLKSEL_POS +: 2]);
  assign pinFn = ctrl_q[`SSP_PINFN_POS +: 2];
  assign sckSel = ssp_uses_sck(pinFn);
  assign soutSel = pinFn[0];
  assign sinSel = pinFn[1];
  assign extClk = clkSel == ssp_pkg::SSP_EXT;
  assign sinBit = sinSel ? link.lineDb : 1'b1;

  always_comb begin
    case (clkSel)
      ssp_pkg::SSP_DIV8: halfLen = `SSP_HALF_DIV8;
      ssp_pkg::SSP_DIV4: halfLen = `SSP_HALF_DIV4;
      ssp_pkg::SSP_DIV2: halfLen = `SSP_HALF_DIV2;
      default: halfLen = `SSP_HALF_DIV2;
    endcase
  end

  assign halfEnd = halfCnt_q == halfLen - 3'h1;
  assign intRise = active_q & ~extClk & halfEnd & ~intSck_q;
  assign intFall = active_q & ~extClk & halfEnd & intSck_q;
  // Pin is taken as synchronous, so the previous sample serves as edge reference
  assign extRise = extClk & sckSel & link.lineSck & ~sckPrev_q;
  assign extFall = extClk & sckSel & ~link.lineSck & sckPrev_q;
  assign rise = intRise | extRise;
  assign fall = intFall | extFall;
  // external clock keeps shifting even after the byte
  assign shiftEn = active_q | extClk;
  // eighth counted rising edge ends the byte
  assign doneSet = rise & active_q & (bitCnt_q == `SSP_LAST_BIT);
  assign intTake = done_q & intSel;
  assign skipHit = skipTest & done_q & ~intSel;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `SSP_CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_q <= accIn;
    end
  end

  // internal clock runs only while active and rests high
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      intSck_q <= 1'b1;
      halfCnt_q <= 3'h0;
    end else if (active_q && !extClk && !start) begin
      if (halfEnd) begin
        halfCnt_q <= 3'h0;
        intSck_q <= ~intSck_q;
      end else begin
        halfCnt_q <= halfCnt_q + 3'h1;
      end
    end else begin
      intSck_q <= 1'b1;
      halfCnt_q <= 3'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sckPrev_q <= 1'b1;
      portIn_q <= 3'h7;
    end else begin
      sckPrev_q <= link.lineSck;
      portIn_q <= {link.lineSck, link.lineDa, link.lineDb};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      active_q <= 1'b0;
      bitCnt_q <= 3'h0;
    end else if (start) begin
      active_q <= 1'b1;
      bitCnt_q <= 3'h0;
    end else if (rise && active_q) begin
      bitCnt_q <= bitCnt_q + 3'h1;
      if (bitCnt_q == `SSP_LAST_BIT) begin
        active_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sr_q <= 8'h00;
    end else if (loadSr) begin
      sr_q <= {bIn, accIn};
    end else if (rise && shiftEn) begin
      // received bit enters at bit 7
      sr_q <= {sinBit, sr_q[7:1]};
    end
  end

  // output bit changes on the falling edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      soutBit_q <= 1'b1;
    end else if (loadSr) begin
      soutBit_q <= accIn[0];
    end else if (fall && shiftEn) begin
      soutBit_q <= sr_q[0];
    end
  end

  // flag set on completion; a set beats any clear in the same cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'b0;
    end else if (doneSet) begin
      done_q <= 1'b1;
    // start, interrupt or taken skip clears the flag
    end else if (start || intTake || skipHit) begin
      done_q <= 1'b0;
    end
  end

  // flag reported by interrupt or by the skip test
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      intReq_q <= 1'b0;
      skipTaken_q <= 1'b0;
    end else begin
      intReq_q <= intTake;
      skipTaken_q <= skipHit;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hsLevel_q <= 1'b1;
      hsSkip_q <= 1'b0;
    end else begin
      if (hsSetHigh) begin
        hsLevel_q <= 1'b1;
      end else if (hsSetLow) begin
        hsLevel_q <= 1'b0;
      end
      hsSkip_q <= hsTestLow & ~link.lineRdy;
    end
  end

  // serial clock pin is an output only with the internal clock; as a plain pin it follows portOe[2]
  assign link.devSckO = sckSel ? intSck_q : portOut[2];
  assign link.devSckOe = sckSel ? ~extClk : portOe[2];
  assign link.devDaO = soutSel ? soutBit_q : portOut[1];
  assign link.devDaOe = soutSel | portOe[1];
  assign link.devDbO = portOut[0];
  assign link.devDbOe = ~sinSel & portOe[0];
  assign link.devRdyO = hsLevel_q;
  assign link.devRdyOe = hsDirOut;

  assign ctrlOut = ctrl_q;
  assign srOut = sr_q;
  assign skipTaken = skipTaken_q;
  assign intReq = intReq_q;
  assign doneFlag = done_q;
  assign portIn = portIn_q;
  assign hsSkip = hsSkip_q;
endmodule // ssp_dev

// ==== verilog/ssp_host.sv ====
// Partner end: AXI4-Lite controlled serial master or slave with ready handshake
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "ssp_params.svh"
module ssp_host #(
  parameter int HALF = `SSP_HOST_HALF // Half clock period in cycles, at least 2
) (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Reset, active low
  ssp_link_if.host link, // Serial pins
  input wire logic [4:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [4:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  ssp_pkg::ssp_host_state_t state_q;
  logic [4:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [2:0] ctrl_q;
  logic [7:0] txData_q, rxData_q, txSr_q, rxSr_q;
  logic [2:0] bitCnt_q;
  logic [7:0] halfCnt_q;
  logic done_q, sck_q, sckPrev_q, dOut_q, rdy_q;
  logic master, isTx, wrFire, wrOk, goCmd, doneClr, shifting, halfEnd, rise, fall;

  function automatic logic ssp_mapped(input logic [4:0] a);
    return a == `SSP_H_CTRL || a == `SSP_H_TXDATA || a == `SSP_H_RXDATA ||
      a == `SSP_H_STATUS || a == `SSP_H_CMD;
  endfunction

  assign master = ctrl_q[`SSP_HC_MASTER];
  assign isTx = ctrl_q[`SSP_HC_ISTX];
  assign s_axi_awready = ~awHeld_q & ~bvalid_q;
  assign s_axi_wready = ~wHeld_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign wrFire = awHeld_q & wHeld_q & ~bvalid_q;
  assign wrOk = wrFire & wStrb_q[0];
  assign goCmd = wrOk & (awAddr_q == `SSP_H_CMD) & wData_q[`SSP_HCMD_GO];
  assign doneClr = wrOk & (awAddr_q == `SSP_H_STATUS) & wData_q[`SSP_HS_DONE];
  assign shifting = state_q == ssp_pkg::HS_SHIFT;
  assign halfEnd = halfCnt_q == 8'(HALF - 1);
  assign rise = master ? (shifting & halfEnd & ~sck_q) : (link.lineSck & ~sckPrev_q);
  assign fall = master ? (shifting & halfEnd & sck_q) : (~link.lineSck & sckPrev_q);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 5'h00;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `SSP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= ssp_mapped(awAddr_q) ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= 3'h0;
      txData_q <= 8'h00;
    end else if (wrOk && awAddr_q == `SSP_H_CTRL) begin
      ctrl_q <= wData_q[2:0];
    end else if (wrOk && awAddr_q == `SSP_H_TXDATA) begin
      txData_q <= wData_q[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `SSP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= ssp_mapped(s_axi_araddr) ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      case (s_axi_araddr)
        `SSP_H_CTRL: rdata_q <= {29'h0, ctrl_q};
        `SSP_H_TXDATA: rdata_q <= {24'h0, txData_q};
        `SSP_H_RXDATA: rdata_q <= {24'h0, rxData_q};
        `SSP_H_STATUS: rdata_q <= {29'h0, link.lineRdy, state_q != ssp_pkg::HS_IDLE, done_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // clock rests high and gives exactly eight pulses
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sck_q <= 1'b1;
      halfCnt_q <= 8'h00;
      sckPrev_q <= 1'b1;
    end else begin
      sckPrev_q <= link.lineSck;
      if (shifting && master) begin
        halfCnt_q <= halfEnd ? 8'h00 : halfCnt_q + 8'h01;
        if (halfEnd) begin
          sck_q <= ~sck_q;
        end
      end else begin
        sck_q <= 1'b1;
        halfCnt_q <= 8'h00;
      end
    end
  end

  // one byte per pass through the sequence
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= ssp_pkg::HS_IDLE;
      bitCnt_q <= 3'h0;
      txSr_q <= 8'h00;
      rxSr_q <= 8'h00;
      rxData_q <= 8'h00;
      dOut_q <= 1'b1;
      rdy_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      if (doneClr) begin
        done_q <= 1'b0;
      end
      case (state_q)
        ssp_pkg::HS_IDLE: begin
          if (goCmd) begin
            bitCnt_q <= 3'h0;
            txSr_q <= txData_q;
            dOut_q <= txData_q[0];
            // receiver arms through HS_SETUP, which pulls ready low before shifting
            state_q <= !isTx ? ssp_pkg::HS_SETUP :
              ctrl_q[`SSP_HC_USERDY] ? ssp_pkg::HS_WAITRDY : ssp_pkg::HS_SHIFT;
          end
        end
        ssp_pkg::HS_SETUP: begin
          rdy_q <= 1'b0;
          state_q <= ssp_pkg::HS_SHIFT;
        end
        ssp_pkg::HS_WAITRDY: begin
          if (!link.lineRdy) begin
            state_q <= ssp_pkg::HS_SHIFT;
          end
        end
        ssp_pkg::HS_SHIFT: begin
          if (rise) begin
            rxSr_q <= {link.lineDa, rxSr_q[7:1]};
            txSr_q <= {1'b1, txSr_q[7:1]};
            // Slave changes data just after sampling to leave a full period
            if (!master) begin
              dOut_q <= txSr_q[1];
            end
            bitCnt_q <= bitCnt_q + 3'h1;
            if (bitCnt_q == `SSP_LAST_BIT) begin
              state_q <= ssp_pkg::HS_CLOSE;
            end
          end else if (fall && master) begin
            dOut_q <= txSr_q[0];
          end
        end
        ssp_pkg::HS_CLOSE: begin
          // receiver raises ready in the same cycle as it stores the byte
          rdy_q <= 1'b1;
          rxData_q <= rxSr_q;
          done_q <= 1'b1;
          state_q <= ssp_pkg::HS_IDLE;
        end
        default: state_q <= ssp_pkg::HS_IDLE;
      endcase
    end
  end

  assign link.hostSckO = sck_q;
  assign link.hostSckOe = master;
  assign link.hostDbO = dOut_q;
  assign link.hostDbOe = 1'b1;
  assign link.hostRdyO = rdy_q;
  assign link.hostRdyOe = ~isTx;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule // ssp_host

// ==== sim/ssp_link_assertions.sv ====
// Link-level checks for the serial byte port pair
`timescale 1ns/1ps
module ssp_link_assertions (
  input wire logic clk_sys, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic devSckO, // Device clock drive
  input wire logic devSckOe, // Device clock enable
  input wire logic devDaO, // Device data drive
  input wire logic devDaOe, // Device data enable
  input wire logic hostSckO, // Partner clock drive
  input wire logic hostSckOe, // Partner clock enable
  input wire logic hostDbO, // Partner data drive
  input wire logic hostDbOe, // Partner data enable
  input wire logic lineSck, // Resolved clock line
  input wire logic lineRdy // Resolved ready line
);
  logic [4:0] quiet;
  logic [3:0] falls;
  // Explicit previous level keeps the fall count free of sampled-value calls in procedural code
  logic sckLast;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // A burst ends once the clock line rests high 16 cycles; benches keep a longer gap
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      quiet <= 5'h00;
      falls <= 4'h0;
      sckLast <= 1'b1;
    end else begin
      sckLast <= lineSck;
      quiet <= !lineSck ? 5'h00 : (quiet == 5'h1F ? quiet : quiet + 5'h01);
      if (quiet == 5'h10) begin
        falls <= 4'h0;
      end else if (sckLast && !lineSck) begin
        falls <= falls + 4'h1;
      end
    end
  end
  chk_da_hold_rise: assert property ($rose(lineSck) && devDaOe |-> $stable(devDaO))
    else $error("device data moved at clock rise");
  chk_db_hold_rise: assert property ($rose(lineSck) && hostDbOe |-> $stable(hostDbO))
    else $error("partner data moved at clock rise");
  chk_dev_sck_low: assert property (devSckOe && $fell(devSckO) |-> ##[1:4] devSckO)
    else $error("device clock stuck low");
  chk_host_sck_low: assert property (hostSckOe && $fell(hostSckO) |-> ##[1:8] hostSckO)
    else $error("partner clock stuck low");
  chk_burst_eight: assert property (falls <= 4'h8)
    else $error("more than eight clock pulses in a burst");
  chk_dev_sck_period: assert property (
    devSckOe && $fell(lineSck) && falls < 4'h7 |-> ##[2:8] $fell(lineSck))
    else $error("device clock pulse missing in burst");
  chk_rdy_before_clk: assert property (
    hostSckOe && $fell(lineSck) && falls == 4'h0 |-> !lineRdy)
    else $error("clock started while receiver not ready");
  chk_reset_idle: assert property ($rose(nrst) |-> lineSck && lineRdy && !devSckOe)
    else $error("lines not idle after reset");
endmodule // ssp_link_assertions

// ==== sim/tb_sync_serial_byte_port.sv ====
// Testbench joining the serial port device and its bus-controlled partner
`timescale 1ns/1ps
`include "ssp_params.svh"
module tb_sync_serial_byte_port;
  localparam logic [7:0] PAT [3] = '{8'hA5, 8'h3C, 8'h81};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic wrCtrl = 1'b0, loadSr = 1'b0, start = 1'b0, skipTest = 1'b0, intSel = 1'b0;
  logic hsSetHigh = 1'b0, hsSetLow = 1'b0, hsDirOut = 1'b0, hsTestLow = 1'b0;
  logic [3:0] accIn = 4'h0, bIn = 4'h0, ctrlOut;
  logic [2:0] portOut = 3'h0, portOe = 3'h0, portIn;
  logic [7:0] srOut;
  logic skipTaken, intReq, doneFlag, hsSkip;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fail_count = 0;
  int comparisons = 0;
  always #20 clk_sys = ~clk_sys;
  ssp_link_if link ();
  ssp_dev u_ssp_dev (.clk_sys, .nrst, .link(link), .wrCtrl, .accIn, .bIn, .ctrlOut, .loadSr,
    .srOut, .start, .skipTest, .skipTaken, .intSel, .intReq, .doneFlag, .portOut, .portOe,
    .portIn, .hsSetHigh, .hsSetLow, .hsDirOut, .hsTestLow, .hsSkip);
  ssp_host #(.HALF(4)) u_ssp_host (.clk_sys, .nrst, .link(link), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ssp_link_assertions u_chk (.clk_sys, .nrst, .devSckO(link.devSckO),
    .devSckOe(link.devSckOe), .devDaO(link.devDaO), .devDaOe(link.devDaOe),
    .hostSckO(link.hostSckO), .hostSckOe(link.hostSckOe), .hostDbO(link.hostDbO),
    .hostDbOe(link.hostDbOe), .lineSck(link.lineSck), .lineRdy(link.lineRdy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Bits: wrCtrl, loadSr, start, skipTest, hsSetHigh, hsSetLow, hsTestLow
  task automatic fire(input logic [6:0] m);
    @(posedge clk_sys);
    {wrCtrl, loadSr, start, skipTest, hsSetHigh, hsSetLow, hsTestLow} <= m;
    @(posedge clk_sys);
    {wrCtrl, loadSr, start, skipTest, hsSetHigh, hsSetLow, hsTestLow} <= 7'h00;
  endtask
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_flag(output int n);
    n = 0;
    while (doneFlag !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    chk(32'(ctrlOut), 32'h0, "ctrl reset");
    chk(32'(doneFlag), 32'h0, "done reset");
    chk(32'(link.lineSck), 32'h1, "clock idle");
    axi_read(5'h14, d, r);
    chk(32'(r), 32'(`SSP_RESP_SLVERR), "unmapped read");
    chk(d, 32'h0, "unmapped data");
    axi_write(5'h18, 32'h1, r);
    chk(32'(r), 32'(`SSP_RESP_SLVERR), "unmapped write");
    // Lane 0 strobe low: answered, but must not land
    s_axi_wstrb <= 4'h0;
    axi_write(`SSP_H_CTRL, 32'h7, r);
    s_axi_wstrb <= 4'hF;
    chk(32'(r), 32'(`SSP_RESP_OKAY), "masked write");
    axi_read(`SSP_H_CTRL, d, r);
    chk(d, 32'h0, "host ctrl reset");
    $display("test reset done");
  endtask
  task automatic t_pins;
    accIn <= 4'h0;
    fire(7'h40);
    portOe <= 3'h2;
    portOut <= 3'h0;
    repeat (3) @(posedge clk_sys);
    chk(32'(link.lineDa), 32'h0, "plain data pin");
    chk(32'(portIn), 32'h5, "pin levels");
    portOe <= 3'h0;
    $display("test pins done");
  endtask
  // Device master sends at each internal rate to the partner as receiver
  task automatic t_dev_tx;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    int h;
    for (int i = 0; i < 3; i++) begin
      h = 4 >> i;
      repeat (20) @(posedge clk_sys);
      axi_write(`SSP_H_CTRL, 32'h0, r);
      axi_write(`SSP_H_TXDATA, {24'h0, ~PAT[i]}, r);
      accIn <= {i[1:0], 2'b11};
      fire(7'h40);
      @(posedge clk_sys);
      chk(32'(ctrlOut), 32'({i[1:0], 2'b11}), "ctrl readback");
      accIn <= PAT[i][3:0];
      bIn <= PAT[i][7:4];
      fire(7'h20);
      @(posedge clk_sys);
      chk(32'(srOut), 32'(PAT[i]), "load");
      chk(32'(link.lineDa), 32'(PAT[i][0]), "first bit");
      fire(7'h01);
      @(posedge clk_sys);
      chk(32'(hsSkip), 32'h0, "receiver busy");
      axi_write(`SSP_H_CMD, 32'h1, r);
      fire(7'h01);
      @(posedge clk_sys);
      chk(32'(hsSkip), 32'h1, "receiver ready");
      fire(7'h10);
      @(posedge clk_sys);
      chk(32'(doneFlag), 32'h0, "start clears");
      wait_flag(n);
      chk(32'(n >= 16 * h - 4 && n <= 16 * h + 4), 32'h1, "clock rate");
      chk(32'(srOut), {24'h0, ~PAT[i]}, "device byte");
      axi_read(`SSP_H_RXDATA, d, r);
      chk(d, 32'(PAT[i]), "partner byte");
      axi_read(`SSP_H_STATUS, d, r);
      chk(32'(d[2:0]), 32'h5, "partner status");
      axi_write(`SSP_H_STATUS, 32'h1, r);
    end
    chk(32'(doneFlag), 32'h1, "done held");
    fire(7'h08);
    @(posedge clk_sys);
    chk(32'(skipTaken), 32'h1, "skip taken");
    chk(32'(doneFlag), 32'h0, "skip clears");
    $display("test device transmit done");
  endtask
  // Partner master sends on the external clock; device receives in interrupt mode
  task automatic t_host_tx;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    repeat (20) @(posedge clk_sys);
    intSel <= 1'b1;
    accIn <= 4'hF;
    fire(7'h40);
    accIn <= 4'h6;
    bIn <= 4'h9;
    fire(7'h20);
    hsDirOut <= 1'b1;
    fire(7'h04);
    axi_write(`SSP_H_TXDATA, 32'hC6, r);
    axi_write(`SSP_H_CTRL, 32'h7, r);
    axi_write(`SSP_H_CMD, 32'h1, r);
    repeat (10) @(posedge clk_sys);
    chk(32'(link.lineSck), 32'h1, "held off");
    fire(7'h10);
    fire(7'h02);
    wait_flag(n);
    @(posedge clk_sys);
    chk(32'(intReq), 32'h1, "interrupt");
    chk(32'(doneFlag), 32'h0, "interrupt clears");
    chk(32'(srOut), 32'hC6, "received byte");
    axi_read(`SSP_H_RXDATA, d, r);
    chk(d, 32'h96, "device sent byte");
    fire(7'h04);
    repeat (20) @(posedge clk_sys);
    axi_write(`SSP_H_TXDATA, 32'h39, r);
    axi_write(`SSP_H_CMD, 32'h1, r);
    fire(7'h02);
    repeat (90) @(posedge clk_sys);
    chk(32'(srOut), 32'h39, "ungated shift");
    chk(32'(doneFlag), 32'h0, "no done without start");
    $display("test partner transmit done");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_pins();
    t_dev_tx();
    t_host_tx();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule // tb_sync_serial_byte_port
